/* core/apcm_pkg.sv */
// constants and types shared by the audio port clock monitor
// assumes a 10 MHz system clock and an AXI4-Lite master with 32-bit data
package apcm_pkg;

  // ==========================================================
  // timing
  localparam int CLK_KHZ = 10000;
  localparam int HALT_TIME_US = 50;
  localparam int HALT_CYC = (HALT_TIME_US * CLK_KHZ) / 1000;
  localparam int DETECT_FRAMES = 4;

  // ==========================================================
  // frame period windows in system clock cycles per class
  localparam logic [11:0] PER_32K_LO = 12'h122;
  localparam logic [11:0] PER_32K_HI = 12'h14A;
  localparam logic [11:0] PER_48K_LO = 12'h0C8;
  localparam logic [11:0] PER_48K_HI = 12'h0F0;
  localparam logic [11:0] PER_96K_LO = 12'h064;
  localparam logic [11:0] PER_96K_HI = 12'h078;
  localparam logic [11:0] PER_192K_LO = 12'h032;
  localparam logic [11:0] PER_192K_HI = 12'h03C;

  // ==========================================================
  // bit clocks per frame
  localparam logic [9:0] RATIO_32 = 10'h020;
  localparam logic [9:0] RATIO_64 = 10'h040;
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_512 = 10'h200;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [9:0] CTRL_IDX = 10'h070;
  localparam logic [9:0] FAULT_IDX = 10'h071;
  localparam logic [9:0] RATIO_IDX = 10'h072;
  localparam logic [9:0] SAMPLE_IDX = 10'h073;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef enum logic [1:0] {
    APCM_RATE_32K,
    APCM_RATE_48K,
    APCM_RATE_96K,
    APCM_RATE_192K
  } apcm_rate_t;

  // clock_fault_status layout, low byte
  typedef struct packed {
    logic [1:0] spare;
    apcm_rate_t rate;
    logic rate_ok;
    logic bad_ratio;
    logic halt;
    logic err;
  } apcm_status_t;

endpackage

/* core/apcm_top.sv */
// audio port clock monitor: bit clock domain frame capture plus
// system clock rate detection, halt timeout and fault register.
// assumes bit_clk comes from the audio source and may stop.
`timescale 1ns/100ps

// Summary of operation
// - the link is bit clock, word/frame clock and serial data, data shifted on the bit clock.
// - the word clock is a channel clock in two-channel formats and a frame sync in TDM.
// - processing and converter clocks are selected from the bit clock, no master clock.
// - the sample rate class is detected from the frame period and drives the clock select.
// - supported ratios are 32 and 64 in two-channel mode and a per-rate TDM set.
// - a halt or unsupported ratio sets the clock error in the fault status register.
// - on a halt the outputs go high impedance and return by themselves afterwards.
// - on a clock stop the core sleeps and resumes on recovery with its state kept.
// - a rate change during operation is re-detected after the halt.
// - samples are two's complement, msb first, at most 32 bits.
// - a frame starts at the rising edge of the frame sync, high one bit clock or more.
module apcm_top import apcm_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // system clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // audio link
  input wire logic bit_clk,
  input wire logic word_frame_clock,
  input wire logic serial_audio_in,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // device side
  output logic amp_hiz,
  output logic core_sleep,
  output logic clk_error,
  output apcm_rate_t clk_rate_sel,
  output logic [31:0] audio_sample,
  output logic sample_valid
);

  if (ADDR_W < 12 || ADDR_W > 32) begin
    $error("ADDR_W must be 12..32");
  end

  // ==========================================================
  // decode functions
  function automatic logic [2:0] rate_of(input logic [11:0] p);
    rate_of = 3'h0;
    if (p >= PER_32K_LO && p <= PER_32K_HI) rate_of = {1'b1, APCM_RATE_32K};
    if (p >= PER_48K_LO && p <= PER_48K_HI) rate_of = {1'b1, APCM_RATE_48K};
    if (p >= PER_96K_LO && p <= PER_96K_HI) rate_of = {1'b1, APCM_RATE_96K};
    if (p >= PER_192K_LO && p <= PER_192K_HI) begin
      rate_of = {1'b1, APCM_RATE_192K};
    end
  endfunction

  function automatic logic ratio_ok(input logic tdm, input logic [1:0] c,
                                    input logic [9:0] r);
    if (!tdm) begin
      ratio_ok = (r == RATIO_32) || (r == RATIO_64);
    end else begin
      case (c)
        2'h1: ratio_ok = (r == RATIO_128) || (r == RATIO_256) ||
                         (r == RATIO_512);
        2'h2: ratio_ok = (r == RATIO_128) || (r == RATIO_256);
        default: ratio_ok = (r == RATIO_128);
      endcase
    end
  endfunction

  // ==========================================================
  // link domain
  // reset reaches the link through two flops; the link clock may stop,
  // so this reset only takes effect while the source is clocking
  logic lrst_s1_reg, lrst_n_reg;
  logic wfc_reg, wfc_prev_reg;
  logic [9:0] bit_cnt_reg;
  logic [9:0] ratio_hold_reg;
  logic [31:0] shift_reg, sample_hold_reg;
  logic frame_tgl_reg;
  wire frame_rise = wfc_reg & ~wfc_prev_reg;
  wire [9:0] bit_cnt_next = (bit_cnt_reg == 10'h3FF) ? bit_cnt_reg :
                            bit_cnt_reg + 10'h001;

  always_ff @(posedge bit_clk) begin
    lrst_s1_reg <= aresetn;
    lrst_n_reg <= lrst_s1_reg;
  end

  always_ff @(posedge bit_clk) begin
    if (!lrst_n_reg) begin
      wfc_reg <= 1'b0;
      wfc_prev_reg <= 1'b0;
      shift_reg <= 32'h0;
    end else begin
      wfc_reg <= word_frame_clock;
      wfc_prev_reg <= wfc_reg;
      shift_reg <= {shift_reg[30:0], serial_audio_in};
    end
  end

  // one counter serves both modes: a channel clock rises once per
  // frame just like a frame sync, so the ratio is per frame either way
  always_ff @(posedge bit_clk) begin
    if (!lrst_n_reg) begin
      bit_cnt_reg <= 10'h0;
      ratio_hold_reg <= 10'h0;
      sample_hold_reg <= 32'h0;
      frame_tgl_reg <= 1'b0;
    end else if (frame_rise) begin
      bit_cnt_reg <= 10'h001;
      ratio_hold_reg <= bit_cnt_reg;
      sample_hold_reg <= shift_reg;
      frame_tgl_reg <= ~frame_tgl_reg;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  a_frame_restart: assert property (
    @(posedge bit_clk) disable iff (!lrst_n_reg)
    frame_rise |=> bit_cnt_reg == 10'h001 && $changed(frame_tgl_reg))
    else $error("bit count did not restart at frame start");

  // ==========================================================
  // crossing: toggle event, hold words are stable for a whole frame
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  wire frame_evt = tgl_s2_reg ^ tgl_s3_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
    end else begin
      tgl_s1_reg <= frame_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
    end
  end

  // ==========================================================
  // rate detection, halt timeout, fault state
  logic [11:0] per_cnt_reg;
  logic halt_reg, err_reg, bad_ratio_reg, rate_ok_reg;
  logic [9:0] ratio_reg;
  logic [2:0] good_cnt_reg;
  logic tdm_mode_reg;
  apcm_rate_t rate_reg;
  wire [2:0] rate_det = rate_of(per_cnt_reg);
  wire frame_good = rate_det[2] &&
                    ratio_ok(tdm_mode_reg, rate_det[1:0], ratio_hold_reg);
  wire same_rate = rate_det[1:0] == rate_reg;
  wire timeout = per_cnt_reg == 12'(HALT_CYC - 1);
  wire stable_done = good_cnt_reg == 3'(DETECT_FRAMES - 1);
  apcm_status_t status;
  assign status = '{spare: 2'h0, rate: rate_reg, rate_ok: rate_ok_reg,
                    bad_ratio: bad_ratio_reg, halt: halt_reg, err: err_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_cnt_reg <= 12'h0;
      halt_reg <= 1'b1;
    end else if (frame_evt) begin
      per_cnt_reg <= 12'h001;
      halt_reg <= 1'b0;
    end else if (timeout) begin
      halt_reg <= 1'b1;
    end else begin
      per_cnt_reg <= per_cnt_reg + 12'h001;
    end
  end

  // a frame that ends a halt measures the halt itself, so it is never
  // counted good; that is what forces a fresh detection after a change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_reg <= 1'b1;
      good_cnt_reg <= 3'h0;
      bad_ratio_reg <= 1'b0;
      rate_ok_reg <= 1'b0;
      rate_reg <= APCM_RATE_48K;
      ratio_reg <= 10'h0;
    end else if (halt_reg) begin
      err_reg <= 1'b1;
      good_cnt_reg <= 3'h0;
    end else if (frame_evt) begin
      ratio_reg <= ratio_hold_reg;
      rate_ok_reg <= rate_det[2];
      bad_ratio_reg <= rate_det[2] && !frame_good;
      if (rate_det[2]) rate_reg <= apcm_rate_t'(rate_det[1:0]);
      if (!frame_good) begin
        err_reg <= 1'b1;
        good_cnt_reg <= 3'h0;
      end else if (!same_rate) begin
        good_cnt_reg <= 3'h0;
      end else if (stable_done) begin
        err_reg <= 1'b0;
      end else begin
        good_cnt_reg <= good_cnt_reg + 3'h1;
      end
    end
  end

  // outputs stop on any fault and come back alone; the core keeps its
  // program because only a sleep request is given, never a reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      amp_hiz <= 1'b1;
      core_sleep <= 1'b1;
      clk_error <= 1'b1;
      clk_rate_sel <= APCM_RATE_48K;
      audio_sample <= 32'h0;
      sample_valid <= 1'b0;
    end else begin
      amp_hiz <= halt_reg | err_reg;
      core_sleep <= halt_reg;
      clk_error <= err_reg;
      clk_rate_sel <= rate_reg;
      sample_valid <= frame_evt & ~err_reg;
      if (frame_evt) audio_sample <= sample_hold_reg;
    end
  end

  a_halt_timeout: assert property (
    @(posedge aclk) disable iff (!aresetn)
    timeout && !frame_evt |=> halt_reg)
    else $error("no halt after frame timeout");

  a_halt_sets_err: assert property (
    @(posedge aclk) disable iff (!aresetn)
    halt_reg |=> err_reg ##1 clk_error)
    else $error("halt did not raise clock error");

  a_bad_ratio_err: assert property (
    @(posedge aclk) disable iff (!aresetn)
    frame_evt && rate_det[2] && !halt_reg &&
    !ratio_ok(tdm_mode_reg, rate_det[1:0], ratio_hold_reg) |=> err_reg)
    else $error("unsupported ratio not flagged");

  a_hiz_on_halt: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(halt_reg) |=> amp_hiz && core_sleep)
    else $error("outputs not high impedance on halt");

  a_sleep_wakes: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(halt_reg) |=> !core_sleep)
    else $error("core did not wake after clocks return");

  a_err_clear_stable: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $fell(err_reg) |-> $past(stable_done) && $past(frame_good))
    else $error("error cleared before a stable run");

  a_rate_detect: assert property (
    @(posedge aclk) disable iff (!aresetn)
    frame_evt && !halt_reg && rate_det[2] |=>
    rate_reg == $past(rate_det[1:0]) ##1 clk_rate_sel == rate_reg)
    else $error("detected rate not applied");

  a_frame_ends_halt: assert property (
    @(posedge aclk) disable iff (!aresetn)
    frame_evt |=> !halt_reg && per_cnt_reg == 12'h001)
    else $error("frame did not end halt");

  // ==========================================================
  // axi4-lite slave, one write and one read at a time
  wire wr_go = awvalid & wvalid & ~awready & ~bvalid;
  wire rd_go = arvalid & ~arready & ~rvalid;
  wire [9:0] wr_idx = awaddr[11:2];
  wire [9:0] rd_idx = araddr[11:2];
  // a shift rather than a part-select keeps the default 12-bit width legal
  wire wr_hit = wr_idx == CTRL_IDX && (awaddr >> 12) == '0;
  wire rd_top0 = (araddr >> 12) == '0;
  wire rd_hit = rd_top0 && (rd_idx == CTRL_IDX || rd_idx == FAULT_IDX ||
                rd_idx == RATIO_IDX || rd_idx == SAMPLE_IDX);
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0;
    case (rd_idx)
      CTRL_IDX: rd_word = {31'h0, tdm_mode_reg};
      FAULT_IDX: rd_word = {24'h0, status};
      RATIO_IDX: rd_word = {22'h0, ratio_reg};
      SAMPLE_IDX: rd_word = audio_sample;
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdm_mode_reg <= CTRL_RESET[0];
    end else if (wr_go && wr_hit && wstrb[0]) begin
      tdm_mode_reg <= wdata[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awready <= wr_go;
      wready <= wr_go;
      // the response may only follow the address and data handshake
      if (awready) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= rd_go;
      // read data may only follow the address handshake
      if (arready) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule

/* sim/apcm_audio_source.sv */
// audio source model driving bit clock, word/frame clock and serial data
// assumes the bench calls send_frames; the bit clock stands still between
`timescale 1ns/100ps

// ==========================================================
// audio source
module apcm_audio_source (
  // audio link
  output logic bit_clk,
  output logic word_frame_clock,
  output logic serial_audio_in
);

  initial begin
    bit_clk = 1'h0;
    word_frame_clock = 1'h0;
    serial_audio_in = 1'h0;
  end

  // bits run at 30 ns, then the clock halts until the frame period ends
  task automatic send_frames(input logic tdm, input int ratio,
                             input int per_ns, input int count,
                             input logic [31:0] word);
    #7;
    for (int f = 0; f < count; f++) begin
      for (int i = 0; i < ratio; i++) begin
        word_frame_clock = tdm ? (i == 0) : (i < ratio / 2);
        // msb lands one bit after the frame edge, so the word is whole
        // when the port captures it one bit clock past the edge
        serial_audio_in = word[31 - ((i + 31) % 32)];
        #15 bit_clk = 1'h1;
        #15 bit_clk = 1'h0;
      end
      // a stopped source leaves no stale data bit behind
      serial_audio_in = ~serial_audio_in;
      #(per_ns - 30 * ratio);
    end
  endtask

endmodule

/* sim/audio_port_clock_monitor_bench.sv */
// self-checking bench for the audio port clock monitor
// assumes apcm_top and apcm_audio_source; aclk 100 ns, bit clock 30 ns
`timescale 1ns/100ps

// ==========================================================
// bench top
module audio_port_clock_monitor_bench import apcm_pkg::*;;

  typedef struct {
    logic tdm;
    int ratio;
    int per;
    apcm_rate_t rate;
    logic err;
  } apcm_row_t;

  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic amp_hiz, core_sleep, clk_error, sample_valid;
  logic bit_clk, word_frame_clock, serial_audio_in;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, audio_sample, rd, word;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  apcm_rate_t clk_rate_sel;
  int num_errors = 0;
  int comparisons = 0;
  int nvalid = 0;
  // frame periods sit inside the detector windows; last three are bad
  apcm_row_t rows [14] = '{
    '{1'h0, 64, 22000, APCM_RATE_48K, 1'h0},
    '{1'h0, 32, 31000, APCM_RATE_32K, 1'h0},
    '{1'h0, 64, 11000, APCM_RATE_96K, 1'h0},
    '{1'h0, 32, 5500, APCM_RATE_192K, 1'h0},
    '{1'h1, 128, 31000, APCM_RATE_32K, 1'h0},
    '{1'h1, 128, 22000, APCM_RATE_48K, 1'h0},
    '{1'h1, 256, 22000, APCM_RATE_48K, 1'h0},
    '{1'h1, 512, 22000, APCM_RATE_48K, 1'h0},
    '{1'h1, 128, 11000, APCM_RATE_96K, 1'h0},
    '{1'h1, 256, 11000, APCM_RATE_96K, 1'h0},
    '{1'h1, 128, 5500, APCM_RATE_192K, 1'h0},
    '{1'h0, 128, 22000, APCM_RATE_48K, 1'h1},
    '{1'h1, 256, 31000, APCM_RATE_32K, 1'h1},
    '{1'h1, 64, 22000, APCM_RATE_48K, 1'h1}
  };

  apcm_top #(.ADDR_W(12)) uut (
    .aclk(aclk), .aresetn(aresetn), .bit_clk(bit_clk),
    .word_frame_clock(word_frame_clock), .serial_audio_in(serial_audio_in),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .amp_hiz(amp_hiz), .core_sleep(core_sleep),
    .clk_error(clk_error), .clk_rate_sel(clk_rate_sel),
    .audio_sample(audio_sample), .sample_valid(sample_valid)
  );

  apcm_audio_source src (
    .bit_clk(bit_clk),
    .word_frame_clock(word_frame_clock),
    .serial_audio_in(serial_audio_in)
  );

  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    if (sample_valid === 1'h1) nvalid++;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic give_up;
    num_errors++;
    $display("timeout waiting for bus answer t=%0t", $time);
    tally_and_finish();
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 40);
    if (bvalid !== 1'h1) give_up();
    resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic axi_read(input logic [11:0] a);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 40);
    if (rvalid !== 1'h1) give_up();
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    aresetn = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    // the link domain needs bit clock edges while reset is held
    fork
      begin
        repeat (8) @(posedge aclk);
        check({amp_hiz, core_sleep, clk_error}, 3'h7);
        check(32'(clk_rate_sel), 32'h1);
        check({bvalid, rvalid, sample_valid}, 3'h0);
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
      end
      src.send_frames(1'h0, 64, 2000, 1, 32'h0000_0000);
    join
    $display("reset test done");
    axi_read({CTRL_IDX, 2'h0});
    check(rd, 32'(CTRL_RESET));
    axi_read({FAULT_IDX, 2'h0});
    check(rd[1:0], 2'h3);
    axi_write({FAULT_IDX, 2'h0}, 32'h0000_0000);
    axi_read({FAULT_IDX, 2'h0});
    check(rd[1:0], 2'h3);
    axi_read(12'h0F0);
    check({resp, rd}, {RESP_SLVERR, 32'h0000_0000});
    axi_write(12'h0F0, 32'hFFFF_FFFF);
    check(resp, RESP_SLVERR);
    $display("register test done");
    foreach (rows[k]) begin
      word = 32'h9E37_79B9 * (k + 1);
      axi_write({CTRL_IDX, 2'h0}, {31'h0, rows[k].tdm});
      axi_read({CTRL_IDX, 2'h0});
      check(rd[0], rows[k].tdm);
      nvalid = 0;
      src.send_frames(rows[k].tdm, rows[k].ratio, rows[k].per, 8, word);
      check({clk_error, amp_hiz}, {2{rows[k].err}});
      check(core_sleep, 1'h0);
      axi_read({FAULT_IDX, 2'h0});
      check(rd[2:0], {rows[k].err, 1'h0, rows[k].err});
      axi_read({RATIO_IDX, 2'h0});
      check(rd, rows[k].ratio);
      if (!rows[k].err) begin
        check(32'(clk_rate_sel), 32'(rows[k].rate));
        check(audio_sample, word);
        check(nvalid > 0, 1'h1);
        axi_read({SAMPLE_IDX, 2'h0});
        check(rd, word);
      end else begin
        check(nvalid, 0);
      end
      // clocks held still long enough for a rate change
      repeat (1100) @(posedge aclk);
      check({core_sleep, amp_hiz, clk_error}, 3'h7);
      $display("row %0d done", k);
    end
    tally_and_finish();
  end

endmodule
